// >>> core/bridge_pkg.sv
/*
 * Shared constants and carriers for the AXI3 to Avalon-MM adapter.
 * Assumes one clock and one synchronous reset shared by every port.
 */
`default_nettype none

package bridge_pkg;

	// carried widths; limits: address 64, id 18, data 1024 bits
	localparam int ADDR_W     = 32;
	localparam int ID_W       = 4;
	localparam int DATA_W     = 32;
	localparam int BYTE_W     = 8;
	localparam int STRB_W     = DATA_W / BYTE_W;
	localparam int ADDR_LSB   = $clog2(STRB_W);
	localparam int MAX_ADDR_W = 64;
	localparam int MAX_ID_W   = 18;
	localparam int MAX_DATA_W = 1024;

	// address bit that steers a command to the Avalon side
	localparam int AVL_SEL_DEF = 31;

	localparam logic [2:0] DATA_SIZE = 3'(ADDR_LSB);

	// register map of the adapter's own control port
	localparam int          CSR_ADDR_W   = 4;
	localparam logic [3:0]  CSR_CTRL_OFS = 4'h0;
	localparam logic [3:0]  CSR_STAT_OFS = 4'h4;
	localparam int          CTRL_DEEP    = 0;
	localparam int          CTRL_AVO     = 1;
	localparam logic [1:0]  CTRL_RST     = 2'h0;
	localparam int          STAT_TO_AV   = 4;
	localparam int          STAT_BUSY    = 5;

	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  BURST_FIXED  = 2'h0;
	localparam logic [1:0]  BURST_INCR   = 2'h1;
	localparam logic [1:0]  BURST_WRAP   = 2'h2;
	localparam logic [1:0]  LOCK_NORMAL  = 2'h0;
	localparam logic [1:0]  LOCK_LOCKED  = 2'h2;
	localparam logic [3:0]  CACHE_AVALON = 4'h0;
	localparam logic [3:0]  AVM_BURST_ONE = 4'h1;

	typedef struct packed {
		logic [ID_W-1:0]   id;
		logic [ADDR_W-1:0] addr;
		logic [3:0]        len;
		logic [2:0]        size;
		logic [1:0]        burst;
		logic [1:0]        lock;
		logic [3:0]        cache;
		logic [2:0]        prot;
	} axi_cmd_type;

	typedef struct packed {
		logic [ID_W-1:0]   id;
		logic [DATA_W-1:0] data;
		logic [STRB_W-1:0] strb;
		logic              last;
	} axi_w_type;

	typedef struct packed {
		logic [ID_W-1:0] id;
		logic [1:0]      resp;
	} axi_b_type;

	typedef struct packed {
		logic [ID_W-1:0]   id;
		logic [DATA_W-1:0] data;
		logic [1:0]        resp;
		logic              last;
	} axi_r_type;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_AXI_WR   = 4'h1,
		ST_AXI_WB   = 4'h2,
		ST_AXI_RD   = 4'h3,
		ST_AV_WR    = 4'h4,
		ST_AV_B     = 4'h5,
		ST_AV_RD    = 4'h6,
		ST_AV_RWAIT = 4'h7,
		ST_AV_RRESP = 4'h8
	} state_type;

endpackage

`default_nettype wire

// >>> core/axi_avalon_bridge.sv
/*
 * AXI3 subordinate port feeding either an AXI3 slave (pass-through) or
 * an Avalon-MM slave (split into single-beat transfers), plus a small
 * Avalon-MM control port with waitrequest.
 * Assumes all ports share sys_clk_in and nrst_in, and that the AXI
 * manager holds valid and payload until ready, as AXI requires.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01 - carry 64-bit addresses, ids up to 18 bits; addresses here are 32-bit (ADDR_W)
// R02 - data up to 1024 bits, 8-bit lanes
// R03 - cache attributes reach AXI slave unchanged
// R04 - all responses come from terminal slave; Avalon-side B and OKAY resp are made by the adapter
// R05 - Avalon write response once slave accepts
// R06 - non-modifiable commands keep address, length, size
// R07 - oversized transfer treated modifiable, size reduced
// R08 - split commands into several Avalon transfers
// R09 - Avalon-origin traffic: cache zero, allocate ignored
// R10 - protection bits forwarded untouched
// R11 - exclusive via lock/id/resp; locked unsupported
// R12 - responses return in issue order
// R13 - deep-reorder slaves get constant id zero
// R14 - one target slave outstanding at a time
// R15 - no write while read to slave pending
// R16 - byte lane zero is bits 7:0
// R17 - align unaligned commands toward Avalon only
// R18 - Avalon bursts must not cross 4KB
// R19 - Avalon byte enables should be contiguous
// R20 - narrow read bursts become single reads
// R21 - byte enables follow size, not address
// R22 - Avalon side answers OKAY
module axi_avalon_bridge
	import bridge_pkg::*;
#(
	parameter int AVL_SEL_BIT = AVL_SEL_DEF
) (
	input  wire logic                  sys_clk_in,
	input  wire logic                  nrst_in,
	input  wire logic                  ce_in,
	input  wire logic [CSR_ADDR_W-1:0] csr_address_in,
	input  wire logic                  csr_read_in,
	input  wire logic                  csr_write_in,
	input  wire logic [31:0]           csr_writedata_in,
	output logic      [31:0]           csr_readdata_out,
	output logic                       csr_waitrequest_out,
	input  wire axi_cmd_type           s_aw_in,
	input  wire logic                  s_awvalid_in,
	output logic                       s_awready_out,
	input  wire axi_w_type             s_w_in,
	input  wire logic                  s_wvalid_in,
	output logic                       s_wready_out,
	output axi_b_type                  s_b_out,
	output logic                       s_bvalid_out,
	input  wire logic                  s_bready_in,
	input  wire axi_cmd_type           s_ar_in,
	input  wire logic                  s_arvalid_in,
	output logic                       s_arready_out,
	output axi_r_type                  s_r_out,
	output logic                       s_rvalid_out,
	input  wire logic                  s_rready_in,
	output axi_cmd_type                m_aw_out,
	output logic                       m_awvalid_out,
	input  wire logic                  m_awready_in,
	output axi_w_type                  m_w_out,
	output logic                       m_wvalid_out,
	input  wire logic                  m_wready_in,
	input  wire axi_b_type             m_b_in,
	input  wire logic                  m_bvalid_in,
	output logic                       m_bready_out,
	output axi_cmd_type                m_ar_out,
	output logic                       m_arvalid_out,
	input  wire logic                  m_arready_in,
	input  wire axi_r_type             m_r_in,
	input  wire logic                  m_rvalid_in,
	output logic                       m_rready_out,
	output logic      [ADDR_W-1:0]     avm_address_out,
	output logic                       avm_read_out,
	output logic                       avm_write_out,
	output logic      [DATA_W-1:0]     avm_writedata_out,
	output logic      [STRB_W-1:0]     avm_byteenable_out,
	output logic      [3:0]            avm_burstcount_out,
	input  wire logic                  avm_waitrequest_in,
	input  wire logic [DATA_W-1:0]     avm_readdata_in,
	input  wire logic                  avm_readdatavalid_in
);

	// size clipped to the bus width; a wider request is reduced
	function automatic logic [2:0] eff_size(input logic [2:0] s);
		return (s > DATA_SIZE) ? DATA_SIZE : s; // R07
	endfunction

	// lane mask from size at the size-aligned offset; lane i is
	// data[8i+7:8i]
	function automatic logic [STRB_W-1:0] size_be(
		input logic [ADDR_W-1:0] a,
		input logic [2:0]        s);
		logic [2:0]          es;
		logic [ADDR_LSB-1:0] off;
		logic [STRB_W:0]     ones;
		es   = eff_size(s);
		off  = (a[ADDR_LSB-1:0] >> es) << es; // R21
		ones = ((STRB_W+1)'(1) << (32'd1 << es)) - (STRB_W+1)'(1);
		return ones[STRB_W-1:0] << off; // R16
	endfunction

	function automatic logic [ADDR_W-1:0] next_addr(input axi_cmd_type c);
		logic [2:0]        es;
		logic [ADDR_W-1:0] step;
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] wmask;
		es    = eff_size(c.size);
		step  = ADDR_W'(1) << es;
		base  = (c.addr >> es) << es; // R21
		wmask = ((ADDR_W'(c.len) + ADDR_W'(1)) << es) - ADDR_W'(1);
		case (c.burst)
			BURST_FIXED: return c.addr;
			BURST_WRAP:  return (c.addr & ~wmask) | ((base + step) & wmask);
			default:     return base + step;
		endcase
	endfunction

	// attributes toward an AXI slave; address, len, size, prot untouched
	function automatic axi_cmd_type fwd_cmd(
		input axi_cmd_type c,
		input logic [1:0]  ctl);
		axi_cmd_type r;
		r = c; // R06 R10 R01
		if (ctl[CTRL_DEEP])
			r.id = '0; // R13
		if (ctl[CTRL_AVO])
			r.cache = CACHE_AVALON; // R09
		if (c.lock == LOCK_LOCKED)
			r.lock = LOCK_NORMAL; // R11
		return r;
	endfunction

	state_type         state_r;
	state_type         state_nxt;
	axi_cmd_type       cmd_r;
	logic [3:0]        beat_r;
	logic              pend_r;
	logic              wdone_r;
	logic [DATA_W-1:0] rdata_r;
	logic [1:0]        ctrl_r;
	logic              csr_ack_r;
	logic [31:0]       csr_rdata_r;

	wire idle      = (state_r == ST_IDLE);
	wire axi_wr    = (state_r == ST_AXI_WR);
	wire axi_wb    = (state_r == ST_AXI_WB);
	wire axi_rd    = (state_r == ST_AXI_RD);
	wire av_wr     = (state_r == ST_AV_WR);
	wire av_b      = (state_r == ST_AV_B);
	wire av_rd     = (state_r == ST_AV_RD);
	wire av_rwait  = (state_r == ST_AV_RWAIT);
	wire av_rresp  = (state_r == ST_AV_RRESP);
	wire to_av     = av_wr | av_b | av_rd | av_rwait | av_rresp;
	wire last_beat = (beat_r == cmd_r.len);

	// one command in flight: a new one waits for every response, so
	// the target never changes while anything is outstanding and a
	// write never overtakes a read; reads win the idle slot
	assign s_arready_out = ce_in & idle; // R14 R15
	assign s_awready_out = ce_in & idle & ~s_arvalid_in; // R14 R15

	wire ar_take = s_arvalid_in & s_arready_out;
	wire aw_take = s_awvalid_in & s_awready_out;
	wire take    = ar_take | aw_take;
	wire sel_av  = aw_take ? s_aw_in.addr[AVL_SEL_BIT]
	                       : s_ar_in.addr[AVL_SEL_BIT];

	// AXI slave side: command from flops, data and responses pass by
	assign m_aw_out      = fwd_cmd(cmd_r, ctrl_r); // R03
	assign m_ar_out      = fwd_cmd(cmd_r, ctrl_r); // R03
	assign m_awvalid_out = axi_wr & pend_r;
	assign m_arvalid_out = axi_rd & pend_r;
	wire   m_aw_hs       = m_awvalid_out & m_awready_in;
	wire   m_ar_hs       = m_arvalid_out & m_arready_in;
	wire   [ID_W-1:0] w_id = ctrl_r[CTRL_DEEP] ? '0 : s_w_in.id; // R13
	assign m_w_out       = {w_id, s_w_in.data, s_w_in.strb, s_w_in.last};
	assign m_wvalid_out  = axi_wr & ~wdone_r & s_wvalid_in;
	assign m_bready_out  = ce_in & axi_wb & s_bready_in;
	assign m_rready_out  = ce_in & axi_rd & s_rready_in;

	// Avalon side: one word per transfer at a word-aligned address
	wire [ADDR_W-1:0] av_addr = {cmd_r.addr[ADDR_W-1:ADDR_LSB],
	                             {ADDR_LSB{1'b0}}}; // R17
	// a request must not drop under waitrequest, so ce_in must not
	// fall while an Avalon transfer is pending
	assign avm_address_out    = av_addr;
	assign avm_write_out      = ce_in & av_wr & s_wvalid_in; // R08
	assign avm_read_out       = ce_in & av_rd; // R20 R08
	assign avm_writedata_out  = s_w_in.data; // R16 R02
	assign avm_byteenable_out = av_wr ? s_w_in.strb // R19
	                                  : size_be(cmd_r.addr, cmd_r.size);
	assign avm_burstcount_out = AVM_BURST_ONE; // R20
	wire   av_w_acc = avm_write_out & ~avm_waitrequest_in;
	wire   av_r_acc = avm_read_out & ~avm_waitrequest_in;

	assign s_wready_out = ce_in & ((axi_wr & ~wdone_r & m_wready_in) |
	                               (av_wr & ~avm_waitrequest_in));
	wire   w_hs = s_wvalid_in & s_wready_out;

	// responses toward the manager, always under the stored id
	assign s_bvalid_out = (axi_wb & m_bvalid_in) | av_b; // R04 R05
	assign s_b_out.id   = cmd_r.id; // R12
	assign s_b_out.resp = axi_wb ? m_b_in.resp : RESP_OKAY; // R11 R22
	assign s_rvalid_out = (axi_rd & m_rvalid_in) | av_rresp; // R04
	assign s_r_out.id   = cmd_r.id; // R12
	assign s_r_out.data = axi_rd ? m_r_in.data : rdata_r;
	assign s_r_out.resp = axi_rd ? m_r_in.resp : RESP_OKAY; // R22
	assign s_r_out.last = axi_rd ? m_r_in.last : last_beat;
	wire   b_hs = s_bvalid_out & s_bready_in;
	wire   r_hs = s_rvalid_out & s_rready_in;

	wire aw_done = ~pend_r | m_aw_hs;
	wire w_done  = wdone_r | (w_hs & s_w_in.last);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (ar_take)
					state_nxt = sel_av ? ST_AV_RD : ST_AXI_RD;
				else if (aw_take)
					state_nxt = sel_av ? ST_AV_WR : ST_AXI_WR;
			end
			ST_AXI_WR: begin
				if (aw_done & w_done)
					state_nxt = ST_AXI_WB;
			end
			ST_AXI_WB, ST_AV_B: begin
				if (b_hs)
					state_nxt = ST_IDLE;
			end
			ST_AXI_RD: begin
				if (r_hs & m_r_in.last)
					state_nxt = ST_IDLE;
			end
			ST_AV_WR: begin
				if (av_w_acc & s_w_in.last)
					state_nxt = ST_AV_B; // R05
			end
			ST_AV_RD: begin
				if (av_r_acc)
					state_nxt = ST_AV_RWAIT;
			end
			ST_AV_RWAIT: begin
				if (avm_readdatavalid_in)
					state_nxt = ST_AV_RRESP;
			end
			ST_AV_RRESP: begin
				if (r_hs)
					state_nxt = last_beat ? ST_IDLE : ST_AV_RD; // R12
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	wire av_step = av_w_acc | (av_rresp & r_hs);

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			cmd_r  <= '0;
			beat_r <= 4'h0;
		end else if (ce_in) begin
			if (ar_take)
				cmd_r <= s_ar_in;
			else if (aw_take)
				cmd_r <= s_aw_in;
			else if (av_step)
				cmd_r.addr <= next_addr(cmd_r); // R08
			if (take)
				beat_r <= 4'h0;
			else if (av_step)
				beat_r <= beat_r + 4'h1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			state_r <= ST_IDLE;
			pend_r  <= 1'b0;
			wdone_r <= 1'b0;
			rdata_r <= '0;
		end else if (ce_in) begin
			state_r <= state_nxt;
			if (take)
				pend_r <= 1'b1;
			else if (m_aw_hs | m_ar_hs)
				pend_r <= 1'b0;
			if (take)
				wdone_r <= 1'b0;
			else if (axi_wr & w_hs & s_w_in.last)
				wdone_r <= 1'b1;
			if (av_rwait & avm_readdatavalid_in)
				rdata_r <= avm_readdata_in;
		end
	end

	// control port: every access waits exactly one cycle
	wire       csr_req  = csr_read_in | csr_write_in;
	wire       csr_go   = ce_in & csr_req & ~csr_ack_r;
	wire       csr_ctrl = (csr_address_in == CSR_CTRL_OFS);
	wire       csr_stat = (csr_address_in == CSR_STAT_OFS);
	wire [31:0] stat_word = {26'h0, ~idle, to_av, state_r};
	wire [31:0] rd_word  = csr_ctrl ? {30'h0, ctrl_r}
	                     : csr_stat ? stat_word : 32'h0;

	assign csr_waitrequest_out = csr_req & ~(ce_in & csr_ack_r);
	assign csr_readdata_out    = csr_rdata_r;

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			csr_ack_r   <= 1'b0;
			csr_rdata_r <= 32'h0;
			ctrl_r      <= CTRL_RST;
		end else if (ce_in) begin
			csr_ack_r <= csr_req & ~csr_ack_r;
			if (csr_go & csr_read_in)
				csr_rdata_r <= rd_word;
			if (csr_ack_r & csr_write_in & csr_ctrl)
				ctrl_r <= csr_writedata_in[1:0];
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	property p_av_bresp;
		s_bvalid_out && av_b |-> s_b_out.resp == RESP_OKAY;
	endproperty
	a_av_bresp: assert property (p_av_bresp) // R22
		else $error("avalon write response not OKAY");

	property p_wresp_on_accept;
		ce_in && av_w_acc && s_w_in.last |=> s_bvalid_out;
	endproperty
	a_wresp_on_accept: assert property (p_wresp_on_accept) // R05
		else $error("no write response after last beat accepted");

	property p_read_gap;
		ce_in && av_r_acc |=> !avm_read_out [*2];
	endproperty
	a_read_gap: assert property (p_read_gap) // R20
		else $error("second avalon read before data return");

	property p_const_id;
		m_awvalid_out && ctrl_r[CTRL_DEEP] |-> m_aw_out.id == '0;
	endproperty
	a_const_id: assert property (p_const_id) // R13
		else $error("id not replaced for reordering slave");

	property p_keep_id;
		m_arvalid_out && !ctrl_r[CTRL_DEEP] |-> m_ar_out.id == cmd_r.id;
	endproperty
	a_keep_id: assert property (p_keep_id) // R13
		else $error("id altered for in-order slave");

	property p_one_target;
		!idle |=> $stable(cmd_r.id) && (idle || $stable(to_av));
	endproperty
	a_one_target: assert property (p_one_target) // R14
		else $error("command or target changed while busy");

	property p_narrow_be;
		avm_read_out |-> $countones(avm_byteenable_out) ==
			(1 << eff_size(cmd_r.size));
	endproperty
	a_narrow_be: assert property (p_narrow_be) // R21
		else $error("read byte enables do not match size");

	property p_aligned;
		avm_read_out || avm_write_out |->
			avm_address_out[ADDR_LSB-1:0] == '0;
	endproperty
	a_aligned: assert property (p_aligned) // R17
		else $error("unaligned avalon address");

	property p_rdata_order;
		ce_in && av_rwait && avm_readdatavalid_in |=>
			s_rvalid_out && s_r_out.data == $past(avm_readdata_in);
	endproperty
	a_rdata_order: assert property (p_rdata_order) // R12
		else $error("read data not returned next cycle");

	property p_prot_pass;
		m_arvalid_out |-> m_ar_out.prot == cmd_r.prot &&
			m_ar_out.addr == cmd_r.addr && m_ar_out.len == cmd_r.len;
	endproperty
	a_prot_pass: assert property (p_prot_pass) // R10
		else $error("read command attributes altered");

endmodule // axi_avalon_bridge

`default_nettype wire

// >>> verif/far_side_model.sv
/*
 * far side of the adapter: one AXI3 slave and one Avalon-MM slave.
 * assumes the adapter's clock and its synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module far_side_model
	import bridge_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              nrst_in,
	input  wire logic              slow_in,
	input  wire axi_cmd_type       aw_in,
	input  wire logic              awvalid_in,
	input  wire axi_w_type         w_in,
	input  wire logic              wvalid_in,
	input  wire logic              bready_in,
	input  wire axi_cmd_type       ar_in,
	input  wire logic              arvalid_in,
	input  wire logic              rready_in,
	input  wire logic [ADDR_W-1:0] av_addr_in,
	input  wire logic              av_rd_in,
	input  wire logic              av_wr_in,
	input  wire logic [DATA_W-1:0] av_wdata_in,
	input  wire logic [STRB_W-1:0] av_be_in,
	output logic                   awready_out,
	output logic                   wready_out,
	output axi_b_type              b_out,
	output logic                   bvalid_out,
	output logic                   arready_out,
	output axi_r_type              r_out,
	output logic                   rvalid_out,
	output logic                   av_wait_out,
	output logic [DATA_W-1:0]      av_rdata_out,
	output logic                   av_rvalid_out,
	output axi_cmd_type            aw_seen_out,
	output axi_cmd_type            ar_seen_out,
	output logic [ADDR_W-1:0]      av_addr_out,
	output logic [STRB_W-1:0]      av_be_out,
	output logic [7:0]             av_cnt_out
);
	logic              tick_r;
	logic              aw_got_r;
	logic              w_got_r;
	logic [1:0]        gap_r;
	logic [3:0]        beat_r;
	logic [DATA_W-1:0] rd_r;
	logic [DATA_W-1:0] mem [16];
	wire               av_req = av_rd_in | av_wr_in;
	wire               av_take = av_req & ~av_wait_out;
	wire [DATA_W-1:0]  rbeat = {ar_seen_out.addr[27:0], beat_r};
	wire axi_b_type    bv = {aw_seen_out.id, 1'b0, aw_seen_out.lock == 2'h1};
	// slow mode stalls each Avalon request two cycles
	assign av_wait_out = av_req & slow_in & (gap_r != 2'h2);
	assign awready_out = ~slow_in | tick_r;
	assign wready_out = ~slow_in | tick_r;
	assign arready_out = ~slow_in | tick_r;
	// released lines show the inverse, never a stale copy
	assign av_rdata_out = av_rvalid_out ? rd_r : ~rd_r;
	assign b_out = bvalid_out ? bv : ~bv;
	// exclusive answered with the exclusive-okay code
	assign r_out = {ar_seen_out.id, rvalid_out ? rbeat : ~rbeat, 1'b0,
		ar_seen_out.lock == 2'h1, beat_r == ar_seen_out.len};
	always_ff @(posedge clk_in) begin
		tick_r <= ~tick_r;
		gap_r <= (av_req & av_wait_out) ? gap_r + 2'h1 : 2'h0;
		av_rvalid_out <= av_take & av_rd_in;
		if (av_take) begin
			av_cnt_out <= av_cnt_out + 8'h01;
			av_addr_out <= av_addr_in;
			av_be_out <= av_be_in;
			rd_r <= mem[av_addr_in[5:2]];
		end
		for (int i = 0; i < STRB_W; i++)
			if (av_take & av_wr_in & av_be_in[i])
				mem[av_addr_in[5:2]][8*i +: 8] <= av_wdata_in[8*i +: 8];
		if (awvalid_in & awready_out) begin
			aw_seen_out <= aw_in;
			aw_got_r <= 1'b1;
		end
		if (wvalid_in & wready_out & w_in.last)
			w_got_r <= 1'b1;
		if (aw_got_r & w_got_r & ~bvalid_out) begin
			bvalid_out <= 1'b1;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
		end
		if (bvalid_out & bready_in)
			bvalid_out <= 1'b0;
		if (arvalid_in & arready_out) begin
			ar_seen_out <= ar_in;
			rvalid_out <= 1'b1;
			beat_r <= 4'h0;
		end else if (rvalid_out & rready_in) begin
			rvalid_out <= ~r_out.last;
			beat_r <= beat_r + 4'h1;
		end
		if (!nrst_in) begin
			{tick_r, aw_got_r, w_got_r, bvalid_out, rvalid_out} <= '0;
			{gap_r, av_rvalid_out, av_cnt_out} <= '0;
			for (int i = 0; i < 16; i++)
				mem[i] <= '0;
		end
	end
endmodule // far_side_model
`default_nettype wire

// >>> verif/test_axi_avalon_bridge.sv
/*
 * self-checking bench: control port and AXI manager tasks.
 * assumes far_side_model answers on the AXI3 and Avalon-MM sides.
 */
`timescale 1ns/1ps
`default_nettype none
module test_axi_avalon_bridge
	import bridge_pkg::*;
;
	logic                  sys_clk_in = 1'b0;
	logic                  nrst_in = 1'b0;
	logic                  ce_in = 1'b1;
	logic                  slow = 1'b0;
	logic [CSR_ADDR_W-1:0] csr_address_in = '0;
	logic                  csr_read_in = 1'b0, csr_write_in = 1'b0;
	logic [31:0]           csr_writedata_in = '0, csr_readdata_out, rd;
	logic                  csr_waitrequest_out, csr_ack;
	axi_cmd_type           s_aw_in = '0, s_ar_in = '0, m_aw_out, m_ar_out;
	axi_cmd_type           aw_seen, ar_seen;
	axi_w_type             s_w_in = '0, m_w_out;
	axi_b_type             s_b_out, m_b_in, bq;
	axi_r_type             s_r_out, m_r_in;
	axi_r_type             rq[$];
	logic s_awvalid_in = 1'b0, s_wvalid_in = 1'b0, s_bready_in = 1'b0;
	logic s_arvalid_in = 1'b0, s_rready_in = 1'b0;
	logic s_awready_out, s_wready_out, s_bvalid_out, s_arready_out;
	logic s_rvalid_out, m_awvalid_out, m_awready_in, m_wvalid_out;
	logic m_wready_in, m_bvalid_in, m_bready_out, m_arvalid_out;
	logic m_arready_in, m_rvalid_in, m_rready_out;
	logic avm_read_out, avm_write_out, avm_waitrequest_in;
	logic avm_readdatavalid_in;
	logic [ADDR_W-1:0]     avm_address_out, av_addr;
	logic [DATA_W-1:0]     avm_writedata_out, avm_readdata_in;
	logic [STRB_W-1:0]     avm_byteenable_out, av_be;
	logic [3:0]            avm_burstcount_out;
	logic [7:0]            av_cnt, cnt0;
	int                    mismatches = 0, check_count = 0;

	assign csr_ack = ~csr_waitrequest_out;
	always #10 sys_clk_in = ~sys_clk_in;

	axi_avalon_bridge u_dut (.*);

	far_side_model u_far (
		.clk_in(sys_clk_in), .nrst_in(nrst_in), .slow_in(slow),
		.aw_in(m_aw_out), .awvalid_in(m_awvalid_out), .w_in(m_w_out),
		.wvalid_in(m_wvalid_out), .bready_in(m_bready_out),
		.ar_in(m_ar_out), .arvalid_in(m_arvalid_out),
		.rready_in(m_rready_out), .av_addr_in(avm_address_out),
		.av_rd_in(avm_read_out), .av_wr_in(avm_write_out),
		.av_wdata_in(avm_writedata_out), .av_be_in(avm_byteenable_out),
		.awready_out(m_awready_in), .wready_out(m_wready_in),
		.b_out(m_b_in), .bvalid_out(m_bvalid_in),
		.arready_out(m_arready_in), .r_out(m_r_in),
		.rvalid_out(m_rvalid_in), .av_wait_out(avm_waitrequest_in),
		.av_rdata_out(avm_readdata_in),
		.av_rvalid_out(avm_readdatavalid_in),
		.aw_seen_out(aw_seen), .ar_seen_out(ar_seen),
		.av_addr_out(av_addr), .av_be_out(av_be), .av_cnt_out(av_cnt)
	);

	task automatic stop_test();
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	// handshake is sampled at the edge, before that edge's updates land
	task automatic await(ref logic sig);
		int n;
		for (n = 0; n < 200; n++) begin
			@(posedge sys_clk_in);
			if (sig === 1'b1)
				break;
		end
		if (n == 200) begin
			mismatches++;
			stop_test();
		end
	endtask

	task automatic csr(input logic wr, input logic [3:0] a,
			input logic [31:0] wd, output logic [31:0] d);
		@(posedge sys_clk_in);
		csr_address_in <= a;
		csr_writedata_in <= wd;
		csr_read_in <= ~wr;
		csr_write_in <= wr;
		await(csr_ack);
		d = csr_readdata_out;
		csr_read_in <= 1'b0;
		csr_write_in <= 1'b0;
	endtask

	task automatic axi_wr(input axi_cmd_type c, input logic [31:0] d,
			input logic [STRB_W-1:0] s, output axi_b_type b);
		@(posedge sys_clk_in);
		s_aw_in <= c;
		s_awvalid_in <= 1'b1;
		await(s_awready_out);
		s_awvalid_in <= 1'b0;
		for (int i = 0; i <= c.len; i++) begin
			s_w_in <= {c.id, d + DATA_W'(i), s, 1'(i == c.len)};
			s_wvalid_in <= 1'b1;
			await(s_wready_out);
		end
		s_wvalid_in <= 1'b0;
		s_bready_in <= 1'b1;
		await(s_bvalid_out);
		b = s_b_out;
		s_bready_in <= 1'b0;
	endtask

	task automatic axi_rd(input axi_cmd_type c, output axi_r_type q[$]);
		q = {};
		@(posedge sys_clk_in);
		s_ar_in <= c;
		s_arvalid_in <= 1'b1;
		await(s_arready_out);
		s_arvalid_in <= 1'b0;
		s_rready_in <= 1'b1;
		do begin
			await(s_rvalid_out);
			q.push_back(s_r_out);
		end while (s_r_out.last !== 1'b1 && q.size() < 16);
		s_rready_in <= 1'b0;
	endtask

	initial begin
		repeat (2) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		csr(1, 4'h8, 32'hffffffff, rd);
		csr(1, CSR_STAT_OFS, 32'hffffffff, rd);
		csr(0, CSR_CTRL_OFS, '0, rd);
		check(rd, 32'h0);
		csr(0, 4'h8, '0, rd);
		check(rd, 32'h0);
		csr(0, CSR_STAT_OFS, '0, rd);
		check(rd, 32'h0);
		csr(1, CSR_CTRL_OFS, 32'h1, rd);
		csr(0, CSR_CTRL_OFS, '0, rd);
		check(rd, 32'h1);
		// unaligned exclusive write toward the AXI slave, deep reorder on
		axi_wr({4'h5, 32'h00001003, 4'h0, DATA_SIZE, BURST_INCR, 2'h1,
			4'ha, 3'h5}, 32'h12345678, 4'hf, bq);
		check(aw_seen.id, 0);
		check(aw_seen.cache, 4'ha);
		check(aw_seen.prot, 3'h5);
		check({aw_seen.addr, aw_seen.len, aw_seen.size},
			{32'h1003, 4'h0, DATA_SIZE});
		check(aw_seen.lock, 2'h1);
		check(bq.resp, 2'h1);
		// locked burst read with avalon-origin attributes
		csr(1, CSR_CTRL_OFS, 32'h2, rd);
		axi_rd({4'h9, 32'h00000200, 4'h1, DATA_SIZE, BURST_INCR,
			LOCK_LOCKED, 4'hf, 3'h2}, rq);
		check(ar_seen.id, 4'h9);
		check(ar_seen.cache, CACHE_AVALON);
		check(ar_seen.lock, LOCK_NORMAL);
		check(ar_seen.prot, 3'h2);
		check(rq.size(), 2);
		for (int i = 0; i < 2; i++)
			check({rq[i].id, rq[i].data, rq[i].resp, rq[i].last},
				{4'h9, 28'h200, 4'(i), RESP_OKAY, 1'(i == 1)});
		// Avalon side, slave stalling on every request
		csr(1, CSR_CTRL_OFS, 32'h0, rd);
		slow <= 1'b1;
		axi_wr({4'h3, 32'h80000011, 4'h0, DATA_SIZE, BURST_INCR,
			LOCK_NORMAL, 4'h0, 3'h0}, 32'haabbccdd, 4'hc, bq);
		check(bq.resp, RESP_OKAY);
		check(av_addr, 32'h80000010);
		check(av_be, 4'hc);
		check(avm_burstcount_out, AVM_BURST_ONE);
		cnt0 = av_cnt;
		axi_wr({4'h3, 32'h80000020, 4'h1, DATA_SIZE, BURST_INCR,
			LOCK_NORMAL, 4'h0, 3'h0}, 32'h11223344, 4'hf, bq);
		check(av_cnt - cnt0, 8'h2);
		check(av_addr, 32'h80000024);
		axi_rd({4'h6, 32'h80000010, 4'h0, DATA_SIZE, BURST_INCR,
			LOCK_NORMAL, 4'h0, 3'h0}, rq);
		check({rq[0].id, rq[0].data, rq[0].resp},
			{4'h6, 32'haabb0000, RESP_OKAY});
		// narrow two-byte burst from an address that is not word-aligned
		cnt0 = av_cnt;
		axi_rd({4'h6, 32'h80000026, 4'h1, 3'h1, BURST_INCR,
			LOCK_NORMAL, 4'h0, 3'h0}, rq);
		check(av_cnt - cnt0, 8'h2);
		check(av_be, 4'h3);
		check(av_addr, 32'h80000028);
		check({rq.size(), rq[1].last}, {32'd2, 1'b1});
		check(rq[0].data, 32'h11223345);
		csr(0, CSR_STAT_OFS, '0, rd);
		check(rd, 32'h0);
		stop_test();
	end
endmodule // test_axi_avalon_bridge
`default_nettype wire
